// File: temp_pin_pkg.sv
// Constants for the temperature/control pin monitor.
// Assumes a single 25 MHz clock and an APB slave with 32-bit data.
package temp_pin_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int BIAS_MS = 25;
  localparam int DEGLITCH_MS = 10;
  localparam int MONITOR_MS = 100;
  localparam int BIAS_CYC = BIAS_MS * (CLK_HZ / 1000);
  localparam int DEGLITCH_CYC = DEGLITCH_MS * (CLK_HZ / 1000);
  localparam int MONITOR_CYC = MONITOR_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 22;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] MASK_OFF = 8'h08;
  localparam logic [7:0] STATE_OFF = 8'h0c;
  localparam logic [7:0] POWER_OFF = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam logic [4:0] MASK_RESET = 5'h00;
  // Status / mask bit positions
  localparam int EV_TEMP = 0;
  localparam int EV_CTRL_HI = 1;
  localparam int EV_CTRL_LO = 2;
  localparam int EV_DIE = 3;
  localparam int EV_PKT = 4;

  // ****************************************
  // End-transfer packet
  // ****************************************
  localparam logic [7:0] PKT_HEADER = 8'h02;
  localparam logic [7:0] REASON_CHARGE_DONE = 8'h01;
  localparam logic [7:0] REASON_INTERNAL_FAULT = 8'h02;
  localparam logic [7:0] REASON_OVERTEMP = 8'h03;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BIAS = 3'b010,
    ST_MON = 3'b100
  } meas_state_e;

endpackage

// File: temp_pin_monitor.sv
// Temperature/control pin monitor: bias window, monitoring window, shutdown
// handling, die thermal protection, end-transfer requests and power report.
// Assumes analog comparators outside deliver asynchronous levels; APB master on I_MCLK.
`timescale 1ns/1ns
module temp_pin_monitor
  import temp_pin_pkg::*;
#(
  parameter int BIAS_CYCLES = BIAS_CYC,
  parameter int DEGLITCH_CYCLES = DEGLITCH_CYC,
  parameter int MONITOR_CYCLES = MONITOR_CYC
)
(
  input wire logic I_MCLK,
  input wire logic I_ARST_N,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_hot_cmp,
  input wire logic i_cold_cmp,
  input wire logic i_ctrl_high_cmp,
  input wire logic i_ctrl_low_cmp,
  input wire logic i_die_shutdown,
  input wire logic i_die_restart_ok,
  input wire logic [15:0] i_out_power,
  input wire logic [15:0] i_loss_power,
  output logic o_temp_bias_strobe,
  output logic o_output_regulator_off,
  output logic o_rx_shutdown,
  output logic o_charge_done,
  output logic o_fault,
  output logic o_end_transfer_packet_valid,
  output logic [7:0] o_end_transfer_packet_header,
  output logic [7:0] o_end_transfer_packet_reason,
  output logic o_rx_power_valid,
  output logic [15:0] o_rx_power,
  output logic o_irq
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [5:0] sync1;
  logic [5:0] sync2;

  // Analog comparator levels are asynchronous to the clock
  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end
    else
    begin
      sync1 <= {i_die_restart_ok, i_die_shutdown, i_ctrl_low_cmp, i_ctrl_high_cmp,
                i_cold_cmp, i_hot_cmp};
      sync2 <= sync1;
    end
  end

  logic hot_s, cold_s, chi_s, clo_s, dsd_s, dhys_s;
  assign {dhys_s, dsd_s, clo_s, chi_s, cold_s, hot_s} = sync2;

  // ****************************************
  // Measurement sequencer and flags
  // ****************************************
  meas_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CNT_W-1:0] hot_cnt, next_hot_cnt;
  logic [CNT_W-1:0] cold_cnt, next_cold_cnt;
  logic hot_ok, next_hot_ok, cold_ok, next_cold_ok;
  logic ctrl_flag, next_ctrl_flag;
  logic temp_fault, next_temp_fault;
  logic shut_done, next_shut_done;
  logic shut_fault, next_shut_fault;
  logic reg_off, next_reg_off;
  logic pkt_valid, next_pkt_valid;
  logic [7:0] pkt_reason, next_pkt_reason;
  logic pwr_valid, next_pwr_valid;
  logic [15:0] pwr, next_pwr;
  logic ctrl_en;
  logic restart;
  logic run;
  logic bias_end, mon_end;

  assign run = ctrl_en && !o_rx_shutdown;
  assign bias_end = (state == ST_BIAS) && (cnt == CNT_W'(BIAS_CYCLES - 1));
  assign mon_end = (state == ST_MON) && (cnt == CNT_W'(MONITOR_CYCLES - 1));

  // Deglitch counter: counts stable-high cycles, saturates at the filter time
  function automatic logic [CNT_W-1:0] deglitch(input logic lvl, input logic [CNT_W-1:0] c);
    if (!lvl)
      return '0;
    else if (c == CNT_W'(DEGLITCH_CYCLES))
      return c;
    else
      return c + CNT_W'(1);
  endfunction

  // Sequencer, deglitch filters, shutdown latches and packet requests
  always_comb
  begin
    next_state = state;
    next_cnt = cnt + CNT_W'(1);
    next_hot_cnt = '0;
    next_cold_cnt = '0;
    next_hot_ok = hot_ok;
    next_cold_ok = cold_ok;
    next_ctrl_flag = ctrl_flag;
    next_temp_fault = temp_fault;
    next_shut_done = shut_done;
    next_shut_fault = shut_fault;
    next_reg_off = reg_off;
    next_pkt_valid = 1'b0;
    next_pkt_reason = pkt_reason;
    next_pwr_valid = 1'b0;
    next_pwr = pwr;
    case (state)
      ST_IDLE:
      begin
        next_cnt = '0;
        if (run)
          next_state = ST_BIAS;
      end
      ST_BIAS:
      begin
        // Comparators only mean something while the divider is biased
        next_hot_cnt = deglitch(hot_s, hot_cnt);
        next_cold_cnt = deglitch(cold_s, cold_cnt);
        if (next_hot_cnt == CNT_W'(DEGLITCH_CYCLES))
          next_hot_ok = 1'b1;
        if (next_cold_cnt == CNT_W'(DEGLITCH_CYCLES))
          next_cold_ok = 1'b1;
        if (!run)
        begin
          // A cut window must not hand an accepted result to the next one
          next_state = ST_IDLE;
          next_hot_ok = 1'b0;
          next_cold_ok = 1'b0;
        end
        else if (bias_end)
        begin
          next_state = ST_MON;
          next_cnt = '0;
          next_temp_fault = hot_ok || cold_ok;
          if (hot_ok || cold_ok)
            next_shut_fault = 1'b1;
          next_hot_ok = 1'b0;
          next_cold_ok = 1'b0;
        end
      end
      ST_MON:
      begin
        if (run && chi_s)
        begin
          next_ctrl_flag = 1'b1;
          next_shut_done = 1'b1;
        end
        else if (run && clo_s)
        begin
          next_shut_fault = 1'b1;
        end
        if (!run)
        begin
          next_state = ST_IDLE;
        end
        else if (mon_end)
        begin
          next_state = ST_BIAS;
          next_cnt = '0;
          next_pwr = i_out_power + i_loss_power;
          next_pwr_valid = 1'b1;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_cnt = '0;
      end
    endcase
    // Die protection: off at the limit, back on only past the hysteresis
    if (dsd_s)
      next_reg_off = 1'b1;
    else if (dhys_s)
      next_reg_off = 1'b0;
    // One packet per cycle, for the highest-priority newly entered cause: die shutdown, then fault, then charge done
    if (dsd_s && !reg_off)
    begin
      next_pkt_valid = 1'b1;
      next_pkt_reason = REASON_INTERNAL_FAULT;
    end
    else if (next_shut_fault && !shut_fault)
    begin
      next_pkt_valid = 1'b1;
      next_pkt_reason = REASON_OVERTEMP;
    end
    else if (next_shut_done && !shut_done)
    begin
      next_pkt_valid = 1'b1;
      next_pkt_reason = REASON_CHARGE_DONE;
    end
    // Restart wins only when no new cause arrives in the same cycle
    if (restart && !next_pkt_valid)
    begin
      next_shut_done = 1'b0;
      next_shut_fault = 1'b0;
      next_ctrl_flag = 1'b0;
      next_temp_fault = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      hot_cnt <= '0;
      cold_cnt <= '0;
      hot_ok <= 1'b0;
      cold_ok <= 1'b0;
      ctrl_flag <= 1'b0;
      temp_fault <= 1'b0;
      shut_done <= 1'b0;
      shut_fault <= 1'b0;
      reg_off <= 1'b0;
      pkt_valid <= 1'b0;
      pkt_reason <= 8'h00;
      pwr_valid <= 1'b0;
      pwr <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      hot_cnt <= next_hot_cnt;
      cold_cnt <= next_cold_cnt;
      hot_ok <= next_hot_ok;
      cold_ok <= next_cold_ok;
      ctrl_flag <= next_ctrl_flag;
      temp_fault <= next_temp_fault;
      shut_done <= next_shut_done;
      shut_fault <= next_shut_fault;
      reg_off <= next_reg_off;
      pkt_valid <= next_pkt_valid;
      pkt_reason <= next_pkt_reason;
      pwr_valid <= next_pwr_valid;
      pwr <= next_pwr;
    end
  end

  // Outside the bias window the strobe is low and the pin floats for the host
  assign o_temp_bias_strobe = (state == ST_BIAS);
  assign o_output_regulator_off = reg_off;
  assign o_rx_shutdown = shut_done || shut_fault;
  assign o_charge_done = shut_done;
  assign o_fault = shut_fault;
  assign o_end_transfer_packet_valid = pkt_valid;
  assign o_end_transfer_packet_header = PKT_HEADER;
  assign o_end_transfer_packet_reason = pkt_reason;
  assign o_rx_power_valid = pwr_valid;
  assign o_rx_power = pwr;

  // ****************************************
  // APB slave, status and interrupt
  // ****************************************
  logic [4:0] status, next_status;
  logic [4:0] mask, next_mask;
  logic ctrl_en_q, next_ctrl_en;
  logic restart_q, next_restart;
  logic [31:0] rdata, next_rdata;
  logic mapped;
  logic acc;
  logic [4:0] events;

  assign mapped = (i_paddr == CTRL_OFF) || (i_paddr == STATUS_OFF) || (i_paddr == MASK_OFF)
               || (i_paddr == STATE_OFF) || (i_paddr == POWER_OFF);
  assign acc = i_psel && i_penable;
  // Each cause bit follows the very condition that latches its shutdown cause; the packet bit follows pkt_valid
  assign events = {pkt_valid, dsd_s && !reg_off,
                   (state == ST_MON) && run && !chi_s && clo_s && !shut_fault,
                   next_shut_done && !shut_done, bias_end && run && (hot_ok || cold_ok)};
  assign ctrl_en = ctrl_en_q;
  assign restart = restart_q;

  // Register writes, read data capture in setup, read-to-clear status
  always_comb
  begin
    next_ctrl_en = ctrl_en_q;
    next_restart = 1'b0;
    next_mask = mask;
    next_status = status;
    next_rdata = rdata;
    if (i_psel && !i_penable && !i_pwrite)
    begin
      case (i_paddr)
        CTRL_OFF: next_rdata = {30'h0, 1'b0, ctrl_en_q};
        STATUS_OFF: next_rdata = {27'h0, status};
        MASK_OFF: next_rdata = {27'h0, mask};
        STATE_OFF: next_rdata = {24'h0, reg_off, shut_fault, shut_done, temp_fault, ctrl_flag,
                                 state};
        POWER_OFF: next_rdata = {16'h0, pwr};
        default: next_rdata = 32'h0;
      endcase
    end
    if (acc && i_pwrite && i_paddr == CTRL_OFF)
    begin
      next_ctrl_en = i_pwdata[CTRL_EN_BIT];
      next_restart = i_pwdata[CTRL_RESTART_BIT];
    end
    if (acc && i_pwrite && i_paddr == MASK_OFF)
      next_mask = i_pwdata[4:0];
    if (acc && !i_pwrite && i_paddr == STATUS_OFF)
      next_status = 5'h00;
    next_status = next_status | events; // set beats the read clear
  end

  // Register file
  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      ctrl_en_q <= CTRL_EN_RESET;
      restart_q <= 1'b0;
      mask <= MASK_RESET;
      status <= 5'h00;
      rdata <= 32'h0;
    end
    else
    begin
      ctrl_en_q <= next_ctrl_en;
      restart_q <= next_restart;
      mask <= next_mask;
      status <= next_status;
      rdata <= next_rdata;
    end
  end

  assign o_prdata = rdata;
  assign o_pready = acc; // zero wait states: data was captured in setup
  assign o_pslverr = acc && !mapped;
  assign o_irq = |(status & mask);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);

  bias_window_a: assert property ($fell(o_temp_bias_strobe) && $past(run)
    |-> $past(cnt) == CNT_W'(BIAS_CYCLES - 1)) else $error("bias window length wrong");
  deglitch_len_a: assert property ($rose(hot_ok)
    |-> $past(hot_cnt) == CNT_W'(DEGLITCH_CYCLES - 1)) else $error("hot deglitch too short");
  temp_act_a: assert property ($rose(temp_fault)
    |-> $past(state) == ST_BIAS && o_fault) else $error("temperature reading not acted on");
  pin_release_a: assert property (bias_end && run
    |=> !o_temp_bias_strobe && state == ST_MON) else $error("pin driven after bias window");
  ctrl_flag_a: assert property ($rose(ctrl_flag)
    |-> $past(state) == ST_MON && $past(chi_s)) else $error("control flag without cause");
  charge_done_a: assert property (state == ST_MON && run && chi_s
    |=> o_rx_shutdown && o_charge_done) else $error("control high not shut down");
  fault_ind_a: assert property (state == ST_MON && run && !chi_s && clo_s
    |=> o_rx_shutdown && o_fault) else $error("control low not shut down");
  reg_off_a: assert property (dsd_s |=> o_output_regulator_off)
    else $error("regulator not turned off");
  resume_a: assert property ($fell(o_output_regulator_off)
    |-> $past(dhys_s) && !$past(dsd_s)) else $error("resumed before hysteresis");
  power_rep_a: assert property (mon_end && run
    |=> o_rx_power_valid && o_rx_power == $past(i_out_power + i_loss_power))
    else $error("received power not reported");
  pkt_send_a: assert property ($rose(o_rx_shutdown)
    |-> o_end_transfer_packet_valid && o_end_transfer_packet_header == 8'h02)
    else $error("no end-transfer packet on shutdown");
  loop_seq_a: assert property (bias_end && run ##1 run [*1]
    |-> state == ST_MON && cnt == '0) else $error("monitor window did not follow bias");

endmodule

// File: temp_pin_partner.sv
// Far side of the temperature/control pin: thermistor divider or host device.
// Assumes the bench picks the condition; the model turns it into comparator levels.
`timescale 1ns/1ns
module temp_pin_partner
(
  input wire logic i_bias_on,
  input wire logic i_hot_req,
  input wire logic i_cold_req,
  input wire logic i_host_high,
  input wire logic i_host_low,
  output logic o_hot_cmp,
  output logic o_cold_cmp,
  output logic o_ctrl_high_cmp,
  output logic o_ctrl_low_cmp
);
  // ****************************************
  // Pin levels
  // ****************************************
  // Thermistor thresholds only mean something while the pin is biased
  assign o_hot_cmp = i_bias_on & i_hot_req;
  assign o_cold_cmp = i_bias_on & i_cold_req;
  // Host drives high only while the device leaves the pin undriven
  assign o_ctrl_high_cmp = ~i_bias_on & i_host_high;
  assign o_ctrl_low_cmp = ~i_bias_on & i_host_low;
endmodule

// File: temp_control_pin_monitor_bench.sv
// Self-checking bench for the pin monitor: APB tasks and pin scenarios.
// Assumes short window parameters and the partner model beside the design.
`timescale 1ns/1ns
module temp_control_pin_monitor_bench;
  import temp_pin_pkg::*;
  localparam int BC = 40;
  localparam int MC = 60;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, bias_on, reg_off, shut, done, fault, pkt_v, pwr_v, irq;
  logic hot_req = 1'b0;
  logic [3:0] cause = 4'h0;
  logic restart_ok = 1'b0;
  logic hot_c, cold_c, hi_c, lo_c;
  logic [7:0] hdr, rsn, pkt_rsn, pkt_hdr;
  logic [15:0] rx_pwr, pwr_seen;
  logic [15:0] out_pwr = 16'hfff0;
  logic [15:0] loss_pwr = 16'h0015;
  int n_pkt = 0;
  int n_errors = 0;
  int checks_done = 0;

  // ****************************************
  // Design, partner and monitors
  // ****************************************
  temp_pin_monitor #(.BIAS_CYCLES(BC), .DEGLITCH_CYCLES(10), .MONITOR_CYCLES(MC)) i_dut (
    .I_MCLK(clk), .I_ARST_N(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_hot_cmp(hot_c), .i_cold_cmp(cold_c),
    .i_ctrl_high_cmp(hi_c), .i_ctrl_low_cmp(lo_c), .i_die_shutdown(cause[3]),
    .i_die_restart_ok(restart_ok), .i_out_power(out_pwr), .i_loss_power(loss_pwr),
    .o_temp_bias_strobe(bias_on), .o_output_regulator_off(reg_off), .o_rx_shutdown(shut),
    .o_charge_done(done), .o_fault(fault), .o_end_transfer_packet_valid(pkt_v),
    .o_end_transfer_packet_header(hdr), .o_end_transfer_packet_reason(rsn),
    .o_rx_power_valid(pwr_v), .o_rx_power(rx_pwr), .o_irq(irq));
  temp_pin_partner i_far (.i_bias_on(bias_on), .i_hot_req(hot_req), .i_cold_req(cause[0]),
    .i_host_high(cause[1]), .i_host_low(cause[2]), .o_hot_cmp(hot_c), .o_cold_cmp(cold_c),
    .o_ctrl_high_cmp(hi_c), .o_ctrl_low_cmp(lo_c));

  always #20 clk = ~clk;

  // Packets and power reports are one-cycle pulses, so latch them here
  always @(posedge clk)
  begin
    if (pkt_v === 1'b1)
    begin
      n_pkt <= n_pkt + 1;
      pkt_rsn <= rsn;
      pkt_hdr <= hdr;
    end
    if (pwr_v === 1'b1)
      pwr_seen <= rx_pwr;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    n_errors++;
    $display("wrong value %s expected event seen timeout", what);
    report_and_stop();
  endtask

  // One APB transfer; the request stands until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 16) timeout("pready");
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'b0, a, 32'h0, d, e);
    chk(nm, exp, d);
  endtask

  // Bounded wait for a strobe level, counting edges
  task automatic wait_strobe(input logic lvl, output int n);
    n = 0;
    while (bias_on !== lvl)
    begin
      @(posedge clk);
      n++;
      if (n > 400) timeout("strobe");
    end
  endtask

  // Raise one shutdown cause, expect one packet with its reason and flags
  task automatic cause_test(input int idx, input logic [7:0] r, input logic [2:0] fl,
                            input logic [31:0] st, input logic [7:0] sv);
    int old;
    int n;
    logic [31:0] d;
    logic e;
    old = n_pkt;
    n = 0;
    cause <= 4'h1 << idx;
    while (n_pkt == old)
    begin
      @(posedge clk);
      n++;
      if (n > 400) timeout("packet");
    end
    cause <= 4'h0;
    chk("reason", {24'h0, r}, {24'h0, pkt_rsn});
    chk("header", 32'h02, {24'h0, pkt_hdr});
    chk("flags", {28'h0, fl, fl[1] | fl[0]}, {28'h0, reg_off, done, fault, shut});
    chk("irq set", 32'h1, {31'h0, irq});
    // The sequencer keeps running through a die shutdown, so its state bits are masked then
    apb(1'b0, STATE_OFF, 32'h0, d, e);
    chk("state reg", {24'h0, sv}, (idx == 3) ? (d & 32'h000000f8) : d);
    rd_chk("status", STATUS_OFF, st);
    @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    if (idx != 3) apb(1'b1, CTRL_OFF, 32'h3, d, e);
    $display("test cause %0d done", idx);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    int nh;
    int nl;
    int old;
    logic [31:0] d;
    logic e;
    repeat (10) @(posedge clk);
    chk("reset outs", 32'h0, {24'h0, bias_on, reg_off, shut, done, fault, pkt_v, pwr_v, irq});
    chk("reset header", 32'h02, {24'h0, hdr});
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("ctrl", CTRL_OFF, 32'h1);
    rd_chk("mask", MASK_OFF, 32'h0);
    apb(1'b0, 8'h14, 32'h0, d, e);
    chk("unmapped data", 32'h0, d);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b1, MASK_OFF, 32'h1f, d, e);
    rd_chk("mask set", MASK_OFF, 32'h1f);
    $display("test registers done");
    wait_strobe(1'b0, nh);
    wait_strobe(1'b1, nh);
    wait_strobe(1'b0, nh);
    wait_strobe(1'b1, nl);
    chk("bias length", BC, nh);
    chk("monitor length", MC, nl);
    chk("rx power", 32'h0005, {16'h0, pwr_seen});
    rd_chk("power reg", POWER_OFF, 32'h0005);
    $display("test windows done");
    old = n_pkt;
    // New output power must show up in the next report
    out_pwr <= 16'h0100;
    wait_strobe(1'b0, nh);
    wait_strobe(1'b1, nh);
    repeat (5) @(posedge clk);
    hot_req <= 1'b1;
    repeat (8) @(posedge clk);
    hot_req <= 1'b0;
    wait_strobe(1'b0, nh);
    repeat (4) @(posedge clk);
    chk("glitch packets", old, n_pkt);
    chk("glitch fault", 32'h0, {31'h0, fault});
    rd_chk("power update", POWER_OFF, 32'h0115);
    $display("test deglitch done");
    cause_test(0, 8'h03, 3'b001, 32'h11, 8'h51);
    cause_test(1, 8'h01, 3'b010, 32'h12, 8'h29);
    cause_test(2, 8'h03, 3'b001, 32'h14, 8'h41);
    restart_ok <= 1'b0;
    cause_test(3, 8'h02, 3'b100, 32'h18, 8'h80);
    repeat (10) @(posedge clk);
    chk("regulator held off", 32'h1, {31'h0, reg_off});
    restart_ok <= 1'b1;
    nh = 0;
    while (reg_off !== 1'b0)
    begin
      @(posedge clk);
      nh++;
      if (nh > 20) timeout("regulator on");
    end
    $display("test hysteresis done");
    // Clearing the enable must park the sequencer with the pin released
    apb(1'b1, CTRL_OFF, 32'h0, d, e);
    rd_chk("state disabled", STATE_OFF, 32'h01);
    chk("strobe disabled", 32'h0, {31'h0, bias_on});
    $display("test disable done");
    report_and_stop();
  end
endmodule
